// [rtl/msr_pkg.sv]
// constants, enumerations and carriers of the module status reporter
// assumes a single 20 MHz clock domain and a 32-bit AHB-Lite register bus
package msr_pkg;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // half period of the shared flash timebase, 0.5 s full period
  localparam int BLINK_HALF_NS = 250000000;
  localparam int BLINK_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int NCH = 40;

  // ************************************************
  // register byte offsets
  // ************************************************
  localparam logic [7:0] OFS_ACT_CHASSIS = 8'h00;
  localparam logic [7:0] OFS_SIMULATED = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_MASK = 8'h44;
  localparam logic [7:0] OFS_CTRL = 8'h48;
  localparam logic [7:0] OFS_PRIMARY = 8'h4C;
  localparam logic [7:0] OFS_EVT_MODULE_INFORMATION_RECORD = 8'h50;
  localparam logic [7:0] OFS_EVT_TIME = 8'h54;
  localparam logic [7:0] OFS_LOG_EN = 8'h60;

  // ************************************************
  // reset values and field positions
  // ************************************************
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [0:0] RST_CTRL = 1'h0;
  localparam logic [15:0] RST_PRIMARY = 16'h0000;
  localparam int ST_CHANGEOVER = 0;
  localparam int ST_EVENT = 1;
  localparam int ST_HEALTH = 2;
  localparam int ST_EJECT = 3;
  localparam int CTRL_SIM_EN = 0;
  localparam int EVT_VALID_BIT = 31;
  localparam int EVT_CLASS_BIT = 9;
  localparam int EVT_VALUE_BIT = 8;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [2:0] {
    MODE_UNKNOWN = 3'b000,
    MODE_CONFIG = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_ACTIVE = 3'b011,
    MODE_MAINTAIN = 3'b100,
    MODE_SHUTDOWN = 3'b101
  } msr_mode_t;

  typedef enum logic [2:0] {
    SL_UNPOWERED = 3'b000,
    SL_STARTUP = 3'b001,
    SL_HEALTHY = 3'b010,
    SL_FAULT = 3'b011,
    SL_FATAL = 3'b100
  } msr_slice_t;

  typedef enum logic [1:0] {
    EDU_NONE = 2'b00,
    EDU_DONE = 2'b01,
    EDU_PARTIAL = 2'b10
  } msr_edu_t;

  // bi-colour led: {red, green}, both lit is amber
  typedef enum logic [1:0] {
    LED_OFF = 2'b00,
    LED_GREEN = 2'b01,
    LED_RED = 2'b10,
    LED_AMBER = 2'b11
  } msr_led_t;

  typedef struct packed {
    logic [7:0] chassis;
    logic [7:0] slot;
    msr_mode_t mode;
    logic healthy;
    logic [2:0] slice_ok;
  } msr_unit_t;

  typedef struct packed {
    msr_mode_t mode;
    msr_edu_t edu;
    logic changeover;
    logic fatal;
  } msr_fp_t;

  typedef struct packed {
    logic valid;
    logic line_fault;
    logic value;
    logic [6:0] chan;
    logic [31:0] stamp;
  } msr_evt_t;

endpackage

// [rtl/msr_status_top.sv]
// module status reporter: information record, event log, front panel leds
// assumes slice and unit data arrive on ref_clk; presence and ejector pins are asynchronous
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps

// Function
// - record channels 1-4 active unit, 5-8 standby, 9 region, 10 primary, 11 simulated
// - active chassis and slot follow the active unit, swapped at changeover
// - chassis and slot read zero for a unit that is absent
// - health channel uses bit zero only, zero means fault
// - mode codes 5 shutdown to 0 unknown or absent
// - region word upper eight bits are zero
// - region bits 0-3 active slices and ejectors, 4-7 standby
// - ejector limit switches feed the ejector-open bits
// - primary flag set only when active unit sits at configured primary position
// - simulated flag only when active absent or simulation enabled
// - enabled output and line fault changes are logged with a timestamp
// - active, standby and educated leds use a bitwise two-of-three vote
// - each health led is driven by its own slice
// - health led off, amber, green, flashing red, steady red by slice state
// - active led green in active or maintain, flashing red in shutdown
// - standby led green in standby, both flash red when fatal
// - educated led off, green, flashing green, flashing amber at changeover
module msr_status_top #(
  parameter int NCH = msr_pkg::NCH,
  parameter int MS_CYCLES = msr_pkg::MS_CYCLES,
  parameter int BLINK_CYCLES = msr_pkg::BLINK_CYCLES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // the two unit positions, index 0 and 1
  input wire msr_pkg::msr_unit_t [1:0] unit_pos,
  input wire logic active_pos,
  input wire logic sim_req,
  // pins, asynchronous
  input wire logic [1:0] present_pin,
  input wire logic [3:0] ejector_open_pin,
  // slice data towards the front panel
  input wire msr_pkg::msr_fp_t [2:0] slice_fp,
  input wire msr_pkg::msr_slice_t [2:0] slice_state,
  // booleans watched for the event log
  input wire logic [NCH-1:0] out_status,
  input wire logic [NCH-1:0] line_fault,
  // indicators and interrupt
  output msr_pkg::msr_led_t [2:0] led_health,
  output msr_pkg::msr_led_t led_active,
  output msr_pkg::msr_led_t led_standby,
  output msr_pkg::msr_led_t led_educated,
  output logic irq
);

  localparam int NMON = 2 * NCH;
  localparam int LOGW = (NMON + 31) / 32;
  localparam logic [5:0] IDX_SIM = msr_pkg::OFS_SIMULATED[7:2];
  localparam logic [5:0] IDX_STATUS = msr_pkg::OFS_STATUS[7:2];
  localparam logic [5:0] IDX_MASK = msr_pkg::OFS_MASK[7:2];
  localparam logic [5:0] IDX_CTRL = msr_pkg::OFS_CTRL[7:2];
  localparam logic [5:0] IDX_PRIMARY = msr_pkg::OFS_PRIMARY[7:2];
  localparam logic [5:0] IDX_EVT_MODULE_INFORMATION_RECORD = msr_pkg::OFS_EVT_MODULE_INFORMATION_RECORD[7:2];
  localparam logic [5:0] IDX_EVT_TIME = msr_pkg::OFS_EVT_TIME[7:2];
  localparam logic [5:0] IDX_LOG = msr_pkg::OFS_LOG_EN[7:2];
  localparam logic [5:0] LOGW6 = 6'(LOGW);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ************************************************
  // pin synchronisers
  // ************************************************
  // three stages; a pin change counts once stages two and three agree
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [5:0] pin_s3_r;
  logic [5:0] pin_r;
  wire [5:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
  wire [5:0] pin_nxt = (pin_s2_r & pin_agree) | (pin_r & ~pin_agree);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_s3_r <= 6'h00;
      pin_r <= 6'h00;
    end else if (ce) begin
      pin_s1_r <= {ejector_open_pin, present_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= pin_nxt;
    end
  end

  wire [1:0] present = pin_r[1:0];
  // either lever open counts as open
  wire [1:0] ejector_open = {pin_r[5] | pin_r[4], pin_r[3] | pin_r[2]};

  // ************************************************
  // information record
  // ************************************************
  logic act_sel_r;
  logic [15:0] primary_r;
  logic [0:0] ctrl_r;

  wire act_pres = present[act_sel_r];
  wire sb_pres = present[~act_sel_r];
  wire msr_pkg::msr_unit_t act_u = unit_pos[act_sel_r];
  wire msr_pkg::msr_unit_t sb_u = unit_pos[~act_sel_r];
  wire act_ej = ejector_open[act_sel_r];
  wire sb_ej = ejector_open[~act_sel_r];

  logic [15:0] module_information_record [0:10];
  assign module_information_record[0] = act_pres ? {8'h00, act_u.chassis} : 16'h0000;
  assign module_information_record[1] = act_pres ? {8'h00, act_u.slot} : 16'h0000;
  assign module_information_record[2] = {15'h0000, act_pres & act_u.healthy};
  assign module_information_record[3] = act_pres ? {13'h0000, act_u.mode} : 16'h0000;
  assign module_information_record[4] = sb_pres ? {8'h00, sb_u.chassis} : 16'h0000;
  assign module_information_record[5] = sb_pres ? {8'h00, sb_u.slot} : 16'h0000;
  assign module_information_record[6] = {15'h0000, sb_pres & sb_u.healthy};
  assign module_information_record[7] = sb_pres ? {13'h0000, sb_u.mode} : 16'h0000;
  assign module_information_record[8] = {8'h00, sb_ej, sb_u.slice_ok & {3{sb_pres}},
                    act_ej, act_u.slice_ok & {3{act_pres}}};
  assign module_information_record[9] = {15'h0000,
                    act_pres & ({act_u.chassis, act_u.slot} == primary_r)};
  assign module_information_record[10] = {15'h0000,
                     sim_req & (~act_pres | ctrl_r[msr_pkg::CTRL_SIM_EN])};

  // ************************************************
  // event log with millisecond timestamp
  // ************************************************
  logic [31:0] ms_div_r;
  logic [31:0] stamp_r;
  logic [NMON-1:0] mon_prev_r;
  logic [NMON-1:0] pend_r;
  logic [LOGW*32-1:0] log_en_r;
  msr_pkg::msr_evt_t evt_r;

  // lowest pending index goes first; later ones wait, none is dropped
  function automatic logic [7:0] first_set(input logic [NMON-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NMON - 1; i >= 0; i--) begin
      if (v[i]) r = 8'(i);
    end
    return r;
  endfunction

  wire [NMON-1:0] mon = {line_fault, out_status};
  wire [NMON-1:0] mon_chg = (mon ^ mon_prev_r) & log_en_r[NMON-1:0];
  wire [7:0] pick = first_set(pend_r);
  wire evt_load = ~evt_r.valid & (|pend_r);
  wire [NMON-1:0] served = evt_load ? (NMON'(1) << pick) : '0;
  // new change wins over service of the same bit
  wire [NMON-1:0] pend_nxt = (pend_r & ~served) | mon_chg;
  wire ms_tick = (ms_div_r == 32'(MS_CYCLES - 1));
  wire pick_lf = (pick >= 8'(NCH));
  wire [7:0] pick_ch = pick_lf ? (pick - 8'(NCH)) : pick;

  // ************************************************
  // ahb-lite slave
  // ************************************************
  logic wr_pend_r;
  logic [5:0] wr_idx_r;
  logic [3:0] sts_r;
  logic [3:0] mask_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic irq_r;

  wire ahb_go = hsel & hready & htrans[1];
  wire [5:0] idx = haddr[7:2];
  wire rd_go = ahb_go & ~hwrite;
  wire hit_module_information_record = (idx <= IDX_SIM);
  wire hit_log = (idx >= IDX_LOG) && (idx < IDX_LOG + LOGW6);
  wire [5:0] log_k = idx - IDX_LOG;
  wire [5:0] wlog_k = wr_idx_r - IDX_LOG;
  wire wr_log = wr_pend_r && (wr_idx_r >= IDX_LOG) && (wr_idx_r < IDX_LOG + LOGW6);
  wire [31:0] evt_module_information_record_word = {evt_r.valid, 21'h000000, evt_r.line_fault, evt_r.value,
                               1'b0, evt_r.chan};
  wire [31:0] rd_word =
    hit_module_information_record ? {16'h0000, module_information_record[idx[3:0]]} :
    hit_log ? log_en_r[32*log_k +: 32] :
    (idx == IDX_STATUS) ? {28'h0000000, sts_r} :
    (idx == IDX_MASK) ? {28'h0000000, mask_r} :
    (idx == IDX_CTRL) ? {31'h00000000, ctrl_r} :
    (idx == IDX_PRIMARY) ? {16'h0000, primary_r} :
    (idx == IDX_EVT_MODULE_INFORMATION_RECORD) ? evt_module_information_record_word :
    (idx == IDX_EVT_TIME) ? evt_r.stamp : 32'h00000000;
  // reading the timestamp word hands the record back to the logger
  wire evt_consume = rd_go & (idx == IDX_EVT_TIME) & evt_r.valid;

  // ************************************************
  // interrupt sources
  // ************************************************
  logic flt_prev_r;
  logic [1:0] ej_prev_r;
  wire changeover = (act_sel_r != active_pos);
  wire flt_now = (act_pres & ~act_u.healthy) | (sb_pres & ~sb_u.healthy);
  wire [3:0] sts_set = {(ejector_open != ej_prev_r), flt_now & ~flt_prev_r, evt_load,
                        changeover};
  wire [3:0] sts_clr = (wr_pend_r && wr_idx_r == IDX_STATUS) ? hwdata[3:0] : 4'h0;
  // set wins over a write-one-to-clear in the same cycle
  wire [3:0] sts_nxt = (sts_r & ~sts_clr) | sts_set;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      act_sel_r <= 1'b0;
      flt_prev_r <= 1'b0;
      ej_prev_r <= 2'b00;
      sts_r <= 4'h0;
      irq_r <= 1'b0;
      ms_div_r <= 32'h00000000;
      stamp_r <= 32'h00000000;
      mon_prev_r <= '0;
      pend_r <= '0;
      evt_r <= '0;
    end else if (ce) begin
      act_sel_r <= active_pos;
      flt_prev_r <= flt_now;
      ej_prev_r <= ejector_open;
      sts_r <= sts_nxt;
      irq_r <= |(sts_r & mask_r);
      ms_div_r <= ms_tick ? 32'h00000000 : ms_div_r + 32'h00000001;
      stamp_r <= ms_tick ? stamp_r + 32'h00000001 : stamp_r;
      mon_prev_r <= mon;
      pend_r <= pend_nxt;
      if (evt_load) begin
        evt_r <= {1'b1, pick_lf, mon_prev_r[pick[6:0]], pick_ch[6:0], stamp_r};
      end else if (evt_consume) begin
        evt_r.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      mask_r <= msr_pkg::RST_MASK;
      ctrl_r <= msr_pkg::RST_CTRL;
      primary_r <= msr_pkg::RST_PRIMARY;
      log_en_r <= '0;
    end else if (ce) begin
      wr_pend_r <= ahb_go & hwrite;
      wr_idx_r <= idx;
      if (rd_go) hrdata_r <= rd_word;
      if (wr_pend_r && wr_idx_r == IDX_MASK) mask_r <= hwdata[3:0];
      if (wr_pend_r && wr_idx_r == IDX_CTRL) ctrl_r <= hwdata[0:0];
      if (wr_pend_r && wr_idx_r == IDX_PRIMARY) primary_r <= hwdata[15:0];
      if (wr_log) log_en_r[32*wlog_k +: 32] <= hwdata;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign irq = irq_r;

  // ************************************************
  // front panel
  // ************************************************
  logic [31:0] blink_cnt_r;
  logic blink_r;
  msr_pkg::msr_led_t [2:0] led_health_r;
  msr_pkg::msr_led_t led_active_r;
  msr_pkg::msr_led_t led_standby_r;
  msr_pkg::msr_led_t led_edu_r;

  wire blink_wrap = (blink_cnt_r == 32'(BLINK_CYCLES - 1));
  wire [6:0] fp_a = slice_fp[0];
  wire [6:0] fp_b = slice_fp[1];
  wire [6:0] fp_c = slice_fp[2];
  wire msr_pkg::msr_fp_t fp_v = (fp_a & fp_b) | (fp_a & fp_c) | (fp_b & fp_c);
  wire msr_pkg::msr_led_t fl_red = blink_r ? msr_pkg::LED_RED : msr_pkg::LED_OFF;
  wire msr_pkg::msr_led_t fl_green = blink_r ? msr_pkg::LED_GREEN : msr_pkg::LED_OFF;
  wire msr_pkg::msr_led_t fl_amber = blink_r ? msr_pkg::LED_AMBER : msr_pkg::LED_OFF;

  wire msr_pkg::msr_led_t act_led_nxt =
    (fp_v.fatal || fp_v.mode == msr_pkg::MODE_SHUTDOWN) ? fl_red :
    (fp_v.mode == msr_pkg::MODE_ACTIVE || fp_v.mode == msr_pkg::MODE_MAINTAIN) ?
      msr_pkg::LED_GREEN : msr_pkg::LED_OFF;
  wire msr_pkg::msr_led_t sb_led_nxt =
    fp_v.fatal ? fl_red :
    (fp_v.mode == msr_pkg::MODE_STANDBY) ? msr_pkg::LED_GREEN : msr_pkg::LED_OFF;
  wire msr_pkg::msr_led_t edu_led_nxt =
    fp_v.changeover ? fl_amber :
    (fp_v.edu == msr_pkg::EDU_DONE) ? msr_pkg::LED_GREEN :
    (fp_v.edu == msr_pkg::EDU_PARTIAL) ? fl_green : msr_pkg::LED_OFF;

  // each health led follows its own slice, no vote
  msr_pkg::msr_led_t [2:0] health_nxt;
  for (genvar g = 0; g < 3; g++) begin : g_health
    assign health_nxt[g] =
      (slice_state[g] == msr_pkg::SL_STARTUP) ? msr_pkg::LED_AMBER :
      (slice_state[g] == msr_pkg::SL_HEALTHY) ? msr_pkg::LED_GREEN :
      (slice_state[g] == msr_pkg::SL_FAULT) ? fl_red :
      (slice_state[g] == msr_pkg::SL_FATAL) ? msr_pkg::LED_RED : msr_pkg::LED_OFF;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      blink_cnt_r <= 32'h00000000;
      blink_r <= 1'b0;
      led_health_r <= '{default: msr_pkg::LED_OFF};
      led_active_r <= msr_pkg::LED_OFF;
      led_standby_r <= msr_pkg::LED_OFF;
      led_edu_r <= msr_pkg::LED_OFF;
    end else if (ce) begin
      blink_cnt_r <= blink_wrap ? 32'h00000000 : blink_cnt_r + 32'h00000001;
      if (blink_wrap) blink_r <= ~blink_r;
      led_health_r <= health_nxt;
      led_active_r <= act_led_nxt;
      led_standby_r <= sb_led_nxt;
      led_edu_r <= edu_led_nxt;
    end
  end

  assign led_health = led_health_r;
  assign led_active = led_active_r;
  assign led_standby = led_standby_r;
  assign led_educated = led_edu_r;

  // ************************************************
  // checks
  // ************************************************
  chk_absent_zero: assert property (!act_pres |-> module_information_record[0] == 16'h0000 && module_information_record[1] == 16'h0000
    && module_information_record[3] == 16'h0000) else $error("absent active unit shows a position");
  chk_health_bit: assert property (module_information_record[2][15:1] == 15'h0000 && module_information_record[6][15:1] == 15'h0000)
    else $error("health channel uses bits above zero");
  chk_mode_range: assert property (module_information_record[3] <= 16'h0005 && module_information_record[7] <= 16'h0005)
    else $error("mode channel out of range");
  chk_region_upper: assert property (rd_go && idx == 6'h08 && ce |=> hrdata[31:8] == 24'h000000)
    else $error("region word upper bits not zero");
  chk_swap_flag: assert property (ce && changeover |=> sts_r[msr_pkg::ST_CHANGEOVER])
    else $error("changeover not flagged");
  chk_primary_flag: assert property (module_information_record[9] != 16'h0000 |-> act_pres
    && {act_u.chassis, act_u.slot} == primary_r) else $error("primary flag without match");
  chk_sim_gate: assert property (module_information_record[10] != 16'h0000 |->
    (!act_pres || ctrl_r[msr_pkg::CTRL_SIM_EN])) else $error("simulated flag not allowed");
  chk_event_load: assert property (ce && !evt_r.valid && (|pend_r) |=> evt_r.valid
    && sts_r[msr_pkg::ST_EVENT]) else $error("pending change not recorded");
  chk_vote_active: assert property (ce && !fp_v.fatal && fp_v.mode == msr_pkg::MODE_ACTIVE
    |=> led_active == msr_pkg::LED_GREEN) else $error("voted active not green");
  chk_health_own: assert property (ce && slice_state[1] == msr_pkg::SL_FATAL
    |=> led_health[1] == msr_pkg::LED_RED) else $error("fatal slice not steady red");
  chk_fatal_pair: assert property (ce && fp_v.fatal |=> led_active == led_standby)
    else $error("fatal leds differ");
  chk_blink_period: assert property (ce && blink_r != $past(blink_r) |->
    $past(blink_cnt_r) == 32'(BLINK_CYCLES - 1)) else $error("blink toggled off period");

  cov_changeover: cover property (ce && changeover);
  cov_event_read: cover property (evt_consume ##1 evt_load);
  cov_irq: cover property (irq && sts_r[msr_pkg::ST_HEALTH]);

endmodule // msr_status_top

// [verification/msr_host_model.sv]
// host side of the register bus: an ahb-lite master doing single word transfers
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps

module msr_host_model (
  // clock
  input wire logic ref_clk,
  // ahb-lite master outputs
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ************************************************
  // one transfer: address phase held until hready, then data phase
  // ************************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // msr_host_model

// [verification/msr_status_top_tb_top.sv]
// self-checking bench of the module status reporter: record, events, irq, leds
// assumes short timebases (ms 10 cycles, blink 4 cycles) and the host model as bus master
`timescale 1ns/1ps

module msr_status_top_tb_top;
  localparam int NCH = 40;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hwrite, hreadyout, hresp, irq;
  logic active_pos = 1'b0;
  logic sim_req = 1'b0;
  logic [1:0] present_pin = 2'b11;
  logic [3:0] ejector_open_pin = 4'h0;
  msr_pkg::msr_unit_t [1:0] unit_pos;
  msr_pkg::msr_fp_t [2:0] slice_fp;
  msr_pkg::msr_slice_t [2:0] slice_state;
  logic [NCH-1:0] out_status = 40'h0;
  logic [NCH-1:0] line_fault = 40'h0;
  msr_pkg::msr_led_t [2:0] led_health;
  msr_pkg::msr_led_t led_active, led_standby, led_educated;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;
  // rows: active position, presence, ejector pins, channels 1..9
  logic row_ap [3] = '{1'b0, 1'b1, 1'b0};
  logic [1:0] row_pres [3] = '{2'b11, 2'b11, 2'b01};
  logic [3:0] row_ej [3] = '{4'h0, 4'h4, 4'h1};
  logic [15:0] row_exp [3][9] = '{
    '{16'h12, 16'h34, 16'h1, 16'h3, 16'h56, 16'h78, 16'h0, 16'h2, 16'h57},
    '{16'h56, 16'h78, 16'h0, 16'h2, 16'h12, 16'h34, 16'h1, 16'h3, 16'h7D},
    '{16'h12, 16'h34, 16'h1, 16'h3, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0F}};

  always #25 ref_clk = ~ref_clk;

  // edges since reset release; the ms stamp is this count over 10
  always @(posedge ref_clk) begin
    if (nrst) cyc <= cyc + 1;
  end

  msr_status_top #(.NCH(NCH), .MS_CYCLES(10), .BLINK_CYCLES(4)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .unit_pos(unit_pos),
    .active_pos(active_pos), .sim_req(sim_req), .present_pin(present_pin),
    .ejector_open_pin(ejector_open_pin), .slice_fp(slice_fp), .slice_state(slice_state),
    .out_status(out_status), .line_fault(line_fault), .led_health(led_health),
    .led_active(led_active), .led_standby(led_standby), .led_educated(led_educated),
    .irq(irq));

  msr_host_model u_host (
    .ref_clk(ref_clk), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] x;
    u_host.xfer(1'b0, a, 32'h0, x);
    chk(x, e, what);
  endtask

  // 16 cycles against the flashing health led of slice 2, which is on half of them
  task automatic flash(input logic [11:0] on_v, input logic [11:0] off_v);
    int n;
    logic on;
    n = 0;
    repeat (16) begin
      @(negedge ref_clk);
      on = (led_health[2] === msr_pkg::LED_RED);
      n += on;
      chk({20'h0, led_active, led_standby, led_educated, led_health}, on ? on_v : off_v, "leds");
    end
    chk(n, 8, "blink");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    unit_pos[0] = {8'h12, 8'h34, msr_pkg::MODE_ACTIVE, 1'b1, 3'b111};
    unit_pos[1] = {8'h56, 8'h78, msr_pkg::MODE_STANDBY, 1'b0, 3'b101};
    slice_fp = 21'h0;
    slice_state = '{msr_pkg::SL_HEALTHY, msr_pkg::SL_STARTUP, msr_pkg::SL_UNPOWERED};
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({hreadyout, hresp, irq, led_active}, 5'h10, "reset outputs");
    @(posedge ref_clk);
    nrst <= 1'b1;
    rd(msr_pkg::OFS_MASK, 32'h0, "mask reset");
    rd(msr_pkg::OFS_PRIMARY, 32'h0, "primary reset");
    for (int r = 0; r < 3; r++) begin
      active_pos <= row_ap[r];
      present_pin <= row_pres[r];
      ejector_open_pin <= row_ej[r];
      repeat (8) @(posedge ref_clk);
      for (int c = 0; c < 9; c++) begin
        rd(8'(4 * c), {16'h0, row_exp[r][c]}, "record");
      end
    end
    present_pin <= 2'b11;
    for (int m = 0; m < 6; m++) begin
      unit_pos[0].mode <= msr_pkg::msr_mode_t'(m);
      repeat (6) @(posedge ref_clk);
      rd(8'h0C, 32'(m), "mode code");
    end
    unit_pos[0].mode <= msr_pkg::MODE_ACTIVE;
    wr(msr_pkg::OFS_PRIMARY, 32'h1234);
    u_host.xfer(1'b0, 8'h24, 32'h0, v);
    chk({31'h0, v != 32'h0}, 32'h1, "primary active");
    wr(msr_pkg::OFS_PRIMARY, 32'h1235);
    rd(8'h24, 32'h0, "primary elsewhere");
    sim_req <= 1'b1;
    rd(8'h28, 32'h0, "simulated disabled");
    wr(msr_pkg::OFS_CTRL, 32'h1);
    u_host.xfer(1'b0, 8'h28, 32'h0, v);
    chk({31'h0, v != 32'h0}, 32'h1, "simulated enabled");
    rd(8'h30, 32'h0, "unmapped read");
    wr(8'h00, 32'hFFFF);
    rd(8'h00, 32'h12, "read only channel");
    // changeover raises status bit 0; irq follows the mask
    wr(msr_pkg::OFS_STATUS, 32'hF);
    active_pos <= 1'b1;
    repeat (4) @(posedge ref_clk);
    u_host.xfer(1'b0, msr_pkg::OFS_STATUS, 32'h0, v);
    chk(v & 32'h1, 32'h1, "changeover status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(msr_pkg::OFS_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(msr_pkg::OFS_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // event log
    wr(msr_pkg::OFS_LOG_EN, 32'h8);
    // change seen one edge later, loaded the edge after with the stamp then standing
    t0 = (cyc + 2) / 10;
    out_status[3] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(msr_pkg::OFS_EVT_MODULE_INFORMATION_RECORD, 32'h8000_0103, "output event");
    rd(msr_pkg::OFS_EVT_MODULE_INFORMATION_RECORD + 8'h4, t0, "time read");
    out_status[5] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    u_host.xfer(1'b0, msr_pkg::OFS_EVT_MODULE_INFORMATION_RECORD, 32'h0, v);
    chk(v & 32'h8000_0000, 32'h0, "unlogged change");
    wr(msr_pkg::OFS_LOG_EN + 8'h4, 32'h100);
    line_fault[0] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    u_host.xfer(1'b0, msr_pkg::OFS_EVT_MODULE_INFORMATION_RECORD, 32'h0, v);
    chk(v & 32'h8000_0300, 32'h8000_0300, "line fault event");
    // bitwise vote: active, maintain, standby gives standby; done, partial, none gives none
    slice_fp <= {msr_pkg::MODE_STANDBY, msr_pkg::EDU_NONE, 2'b00,
                 msr_pkg::MODE_MAINTAIN, msr_pkg::EDU_PARTIAL, 2'b00,
                 msr_pkg::MODE_ACTIVE, msr_pkg::EDU_DONE, 2'b00};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({led_active, led_standby, led_educated, led_health}, 12'h11C, "voted leds");
    slice_fp <= {msr_pkg::MODE_ACTIVE, msr_pkg::EDU_DONE, 2'b00,
                 msr_pkg::MODE_ACTIVE, msr_pkg::EDU_DONE, 2'b00, 7'h0};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({led_active, led_standby, led_educated}, 6'h11, "active educated");
    slice_state <= '{msr_pkg::SL_FAULT, msr_pkg::SL_FATAL, msr_pkg::SL_HEALTHY};
    slice_fp <= {7'h03, 7'h03, 7'h00};
    repeat (3) @(posedge ref_clk);
    flash(12'hAE9, 12'h009);
    slice_fp <= {msr_pkg::MODE_SHUTDOWN, msr_pkg::EDU_PARTIAL, 2'b00,
                 msr_pkg::MODE_SHUTDOWN, msr_pkg::EDU_PARTIAL, 2'b00, 7'h0};
    repeat (3) @(posedge ref_clk);
    flash(12'h869, 12'h009);
    stop_test();
  end
endmodule // msr_status_top_tb_top
